// *** src/window_timeout_watchdog.v ***
// Window and timeout watchdog supervisor with APB register access
//
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "wdt_defines.vh"

//
// Behaviour
// - Writing one clears interrupt flag
// - Timing from own oscillator tick only
// - Exactly one mode: Window, Timeout, Off
// - Period field, default 128 ms
// - Every watchdog register write restarts timer
// - Early trigger in Window mode resets
// - Legal trigger restarts timer, no reset
// - Window overflow causes system reset
// - Timeout overflow with CI flag pending resets
// - Disable pin change in Normal/Standby resets
// - Mode bit change in Normal resets
// - Watchdog reset reloads default period code
// - Disable pin high forces Off
// - Standby mode bit one: Off, interrupt re-enables
// - Standby mode bit locked while interrupt pending
// - Normal, bit zero, pin low: Window
// - Timeout in Standby bit0 or Normal bit1
// - First timeout overflow sets cyclic interrupt
// - Off, Overtemp, Sleep chip modes: Off
module window_timeout_watchdog #(
    parameter TICK_CYCLES = `WDT_TICK_CYCLES
) (
    // Clock, reset, clock enable
    input wire pclk,
    input wire presetn,
    input wire ce,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Chip context
    input wire [2:0] chip_mode,
    input wire wake_event,
    input wire watchdog_disable_pin,
    // Results
    output reg wdog_reset,
    output reg [1:0] wdog_mode,
    output reg int_pending
);

    // ==========================================================
    // Constants
    // Prescaler counts 0 to TICK_LAST, one watchdog tick per wrap
    localparam integer TICK_LAST_FULL = TICK_CYCLES - 1; // Wrap value
    localparam [15:0] TICK_LAST = TICK_LAST_FULL[15:0]; // Prescaler wrap

    // ==========================================================
    // State
    reg dis_meta; // Synchroniser first stage
    reg dis_sync; // Synchronised disable pin
    reg dis_prev; // Previous synchronised level
    reg [15:0] prescale; // Oscillator tick divider
    reg [15:0] count; // Elapsed ticks of this period
    reg [2:0] watchdog_period_select; // Period code
    reg watchdog_mode_ctrl; // Mode-control bit
    reg [`WDT_INT_W-1:0] int_flags; // Sticky interrupt flags
    reg [2:0] last_cause; // Cause of last watchdog reset
    wire [15:0] period_ms; // Current period in ticks

    // ==========================================================
    // Mode selection
    // Pin overrides everything, then chip mode and mode bit decide
    function [1:0] mode_of;
        input pin;
        input [2:0] chip;
        input ctrl;
        input pend;
        begin
            if (pin) begin
                mode_of = `WD_OFF;
            end else if (chip == `CHIP_NORMAL) begin
                mode_of = ctrl ? `WD_TIMEOUT : `WD_WINDOW;
            end else if (chip == `CHIP_STANDBY) begin
                // Mode bit one turns it off unless an interrupt waits
                mode_of = (ctrl && !pend) ? `WD_OFF : `WD_TIMEOUT;
            end else begin
                mode_of = `WD_OFF;
            end
        end
    endfunction

    // Address compare shared by the three registers
    function addr_hit;
        input [7:0] addr;
        input [7:0] reg_addr;
        begin
            addr_hit = (addr == reg_addr);
        end
    endfunction

    // ==========================================================
    // Period lookup
    // New code reaches period_ms one cycle later; harmless, as the
    // count has just restarted from zero when the code changes
    period_table u_table (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .code(watchdog_period_select),
        .period_ms(period_ms)
    );

    // ==========================================================
    // Bus decode
    // Write acts only at the edge where pready is sampled high
    wire access_end = psel & penable & pready; // Transfer completes
    wire wr_fire = access_end & pwrite; // Write takes effect
    // First access cycle only; it is the one wait state
    wire rd_cap = psel & penable & ~pready; // Read data captured
    wire hit_wdog = addr_hit(paddr, `WDT_ADDR_WDOG);
    wire hit_int = addr_hit(paddr, `WDT_ADDR_INT);
    wire hit_stat = addr_hit(paddr, `WDT_ADDR_STAT);
    wire mapped = hit_wdog | hit_int | hit_stat;
    wire wd_write = wr_fire & hit_wdog;
    wire int_write = wr_fire & hit_int;

    // ==========================================================
    // Watchdog events
    wire [15:0] half = {1'b0, period_ms[15:1]}; // Open window start
    wire running = (wdog_mode != `WD_OFF);
    // Checked every cycle: the reset follows the tick that reaches
    // the period by one clock, with no late trigger let through
    wire overflow = running & (count >= period_ms);
    wire ci_pend = int_flags[`WDT_INT_CI];
    // Trigger inside the closed first half of a Window period
    wire early = wd_write & (wdog_mode == `WD_WINDOW)
        & (count < half);
    wire win_ovf = overflow & (wdog_mode == `WD_WINDOW);
    // Timeout overflow resets if CI already waits, else raises CI
    wire to_ovf = overflow & (wdog_mode == `WD_TIMEOUT);
    wire to_ovf_rst = to_ovf & ci_pend;
    wire to_ovf_ci = to_ovf & ~ci_pend;
    wire active_chip = (chip_mode == `CHIP_NORMAL)
        | (chip_mode == `CHIP_STANDBY);
    // Compared after both synchroniser stages; a pin already high
    // when reset ends counts as one change, since dis_prev starts low
    wire pin_chg = active_chip & (dis_sync != dis_prev);
    // Mode bit write is refused in Standby while an interrupt waits
    wire ctrl_lock = (chip_mode == `CHIP_STANDBY) & int_pending;
    wire ctrl_new = pwdata[`WDT_CTRL_BIT];
    wire ctrl_take = wd_write & ~ctrl_lock;
    wire ctrl_chg = ctrl_take & (ctrl_new != watchdog_mode_ctrl)
        & (chip_mode == `CHIP_NORMAL);
    wire rst_evt = early | win_ovf | to_ovf_rst | pin_chg | ctrl_chg;

    // ==========================================================
    // Next interrupt flags: set wins over a same-cycle clear
    reg [`WDT_INT_W-1:0] next_flags;
    always @* begin
        next_flags = int_flags;
        if (int_write) begin
            next_flags = int_flags & ~pwdata[`WDT_INT_W-1:0];
        end
        if (to_ovf_ci) begin
            next_flags[`WDT_INT_CI] = 1'b1;
        end
        // Wake flag stands for the chip's other interrupt sources
        if (wake_event) begin
            next_flags[`WDT_INT_WAKE] = 1'b1;
        end
    end

    // Next reset cause, highest priority first
    // Cause stands until the next watchdog reset, for software to read
    reg [2:0] next_cause;
    always @* begin
        if (early) begin
            next_cause = `CAUSE_EARLY;
        end else if (win_ovf) begin
            next_cause = `CAUSE_WIN_OVF;
        end else if (to_ovf_rst) begin
            next_cause = `CAUSE_TO_OVF;
        end else if (pin_chg) begin
            next_cause = `CAUSE_PIN;
        end else if (ctrl_chg) begin
            next_cause = `CAUSE_CTRL;
        end else begin
            next_cause = last_cause;
        end
    end

    // Next mode; the register then holds one mode at a time
    // Registered int_pending: a re-enable lags its flag by one cycle
    wire [1:0] next_mode = mode_of(dis_sync, chip_mode,
        watchdog_mode_ctrl, int_pending);
    // Any mode change starts a fresh period
    wire restart = rst_evt | wd_write | to_ovf_ci
        | (next_mode != wdog_mode) | ~running;

    // ==========================================================
    // Disable pin synchroniser
    // Two stages against metastability; dis_prev feeds only the
    // change detector and never reads the first stage
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dis_meta <= 1'b0;
            dis_sync <= 1'b0;
            dis_prev <= 1'b0;
        end else if (ce) begin
            dis_meta <= watchdog_disable_pin;
            dis_sync <= dis_meta;
            dis_prev <= dis_sync;
        end
    end

    // ==========================================================
    // Oscillator tick and period timer
    // Counting stops entirely while clock enable is low
    // Held at zero while off, so enabling never inherits a stale count
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale <= 16'h0000;
            count <= 16'h0000;
        end else if (ce) begin
            if (restart) begin
                // Timer starts from zero on every trigger
                prescale <= 16'h0000;
                count <= 16'h0000;
            end else if (prescale == TICK_LAST) begin
                prescale <= 16'h0000;
                count <= count + 16'h0001;
            end else begin
                prescale <= prescale + 16'h0001;
            end
        end
    end

    // ==========================================================
    // Control bits, flags and results
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_period_select <= `WDT_PSEL_DEFAULT;
            watchdog_mode_ctrl <= 1'b0;
            int_flags <= {`WDT_INT_W{1'b0}};
            int_pending <= 1'b0;
            last_cause <= `CAUSE_NONE;
            wdog_reset <= 1'b0;
            wdog_mode <= `WD_OFF;
        end else if (ce) begin
            wdog_reset <= rst_evt; // One-cycle reset request
            wdog_mode <= next_mode;
            int_flags <= next_flags;
            int_pending <= |next_flags;
            last_cause <= next_cause;
            if (rst_evt) begin
                // Watchdog reset brings back the default period
                watchdog_period_select <= `WDT_PSEL_DEFAULT;
            end else if (wd_write) begin
                watchdog_period_select <=
                    pwdata[`WDT_PSEL_MSB:`WDT_PSEL_LSB];
            end
            // Mode bit keeps its value through a watchdog reset
            if (ctrl_take) begin
                watchdog_mode_ctrl <= ctrl_new;
            end
        end
    end

    // ==========================================================
    // APB slave: one wait state, data from registers
    // pready pulses once per transfer, so a master that holds its
    // request until then never sees a second completion
    // Unmapped addresses read zero and raise pslverr
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (ce) begin
            pready <= rd_cap;
            pslverr <= rd_cap & ~mapped; // Unmapped address errors
            if (rd_cap && !pwrite) begin
                prdata <= 32'h00000000; // Reserved bits read zero
                if (hit_wdog) begin
                    prdata[`WDT_PSEL_MSB:`WDT_PSEL_LSB] <=
                        watchdog_period_select;
                    prdata[`WDT_CTRL_BIT] <= watchdog_mode_ctrl;
                    prdata[`WDT_MODE_MSB:`WDT_MODE_LSB] <= wdog_mode;
                end else if (hit_int) begin
                    prdata[`WDT_INT_W-1:0] <= int_flags;
                end else if (hit_stat) begin
                    prdata[`WDT_STAT_CHIP_MSB:`WDT_STAT_CHIP_LSB] <=
                        chip_mode;
                    prdata[`WDT_STAT_PIN] <= dis_sync;
                    prdata[`WDT_STAT_CAUSE_MSB:`WDT_STAT_CAUSE_LSB] <=
                        last_cause;
                end
            end
        end
    end

endmodule // window_timeout_watchdog

// *** pkg/wdt_defines.vh ***
// Constants for the window and timeout watchdog
`ifndef WDT_DEFINES_VH
`define WDT_DEFINES_VH

// ==========================================================
// Register byte addresses
`define WDT_ADDR_WDOG 8'h00
`define WDT_ADDR_INT 8'h04
`define WDT_ADDR_STAT 8'h08

// ==========================================================
// Watchdog register fields
`define WDT_PSEL_LSB 0
`define WDT_PSEL_MSB 2
`define WDT_CTRL_BIT 3
`define WDT_MODE_LSB 4
`define WDT_MODE_MSB 5
`define WDT_PSEL_DEFAULT 3'h4

// ==========================================================
// Interrupt status fields
`define WDT_INT_CI 0
`define WDT_INT_WAKE 1
`define WDT_INT_W 2

// ==========================================================
// Status register fields
`define WDT_STAT_CHIP_LSB 0
`define WDT_STAT_CHIP_MSB 2
`define WDT_STAT_PIN 3
`define WDT_STAT_CAUSE_LSB 4
`define WDT_STAT_CAUSE_MSB 6

// ==========================================================
// Chip operating modes
`define CHIP_OFF 3'h0
`define CHIP_SLEEP 3'h1
`define CHIP_STANDBY 3'h2
`define CHIP_NORMAL 3'h3
`define CHIP_OVERTEMP 3'h4

// ==========================================================
// Watchdog modes
`define WD_OFF 2'h0
`define WD_WINDOW 2'h1
`define WD_TIMEOUT 2'h2

// ==========================================================
// Reset cause codes
`define CAUSE_NONE 3'h0
`define CAUSE_EARLY 3'h1
`define CAUSE_WIN_OVF 3'h2
`define CAUSE_TO_OVF 3'h3
`define CAUSE_PIN 3'h4
`define CAUSE_CTRL 3'h5

// ==========================================================
// Timing: one watchdog tick of the oscillator is 1 ms
`define WDT_CLK_NS 25
`define WDT_TICK_NS 1000000
`define WDT_TICK_CYCLES (`WDT_TICK_NS / `WDT_CLK_NS)

// Period table in ms, eight 16-bit entries, code 0 in low bits
// Codes 0 to 7: 16, 32, 48, 64, 128, 256, 1024, 4096; default code 4
`define WDT_PERIOD_TABLE 128'h1000_0400_0100_0080_0040_0030_0020_0010
// Table entry of the default code, loaded while in reset
`define WDT_PERIOD_DEFAULT 16'h0080

`endif

// *** src/period_table.v ***
// Period-select code to period length lookup, registered output
`timescale 1ns/1ps
`include "wdt_defines.vh"

module period_table #(
    parameter [127:0] TABLE = `WDT_PERIOD_TABLE
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    input wire ce,
    // Lookup
    input wire [2:0] code,
    output reg [15:0] period_ms
);

    // ==========================================================
    // Registered table read; reset value is the default entry
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_ms <= `WDT_PERIOD_DEFAULT;
        end else if (ce) begin
            period_ms <= TABLE[{code, 4'h0} +: 16];
        end
    end

endmodule // period_table

// *** sim/wdt_properties.sv ***
// Port checker for the window and timeout watchdog
`timescale 1ns/1ps
`include "wdt_defines.vh"

// ========================================
// Checker
module wdt_properties (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    input wire ce,
    // Bus
    input wire psel,
    input wire penable,
    input wire pready,
    input wire pslverr,
    // Context and results
    input wire [2:0] chip_mode,
    input wire wake_event,
    input wire watchdog_disable_pin,
    input wire wdog_reset,
    input wire [1:0] wdog_mode,
    input wire int_pending
);
    // Flag sources, delayed since the level lags its cause
    logic src_d1;
    logic src_d2;
    // Source history
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_d1 <= 1'b0;
            src_d2 <= 1'b0;
        end else begin
            src_d1 <= wake_event || wdog_mode == `WD_TIMEOUT;
            src_d2 <= src_d1;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Bus request entering its access phase
    sequence setup_then_access;
        psel && !penable ##1 psel && penable;
    endsequence
    // Pin edge while the chip is awake
    sequence pin_toggle;
        ce && $changed(watchdog_disable_pin) &&
            (chip_mode == `CHIP_STANDBY || chip_mode == `CHIP_NORMAL);
    endsequence
    a_one_wait_state: assert property (setup_then_access |=> pready)
        else $error("pready late");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready too long");
    a_error_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_reset_pulse: assert property (wdog_reset |=> !wdog_reset)
        else $error("reset pulse too long");
    a_mode_legal: assert property (wdog_mode != 2'h3)
        else $error("illegal mode");
    a_pin_forces_off: assert property (
        (ce && watchdog_disable_pin)[*4] |-> wdog_mode == `WD_OFF)
        else $error("pin high but not off");
    a_chip_off_mode: assert property (
        (ce && chip_mode != `CHIP_STANDBY && chip_mode != `CHIP_NORMAL)[*2]
        |-> wdog_mode == `WD_OFF)
        else $error("asleep chip but not off");
    a_pin_change_reset: assert property (
        pin_toggle |-> ##[1:6] wdog_reset)
        else $error("pin change without reset");
    a_int_has_source: assert property (
        $rose(int_pending) |-> src_d1 || src_d2)
        else $error("interrupt without source");
endmodule // wdt_properties

bind window_timeout_watchdog wdt_properties chk_i (.pclk(pclk),
    .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .chip_mode(chip_mode),
    .wake_event(wake_event), .watchdog_disable_pin(watchdog_disable_pin),
    .wdog_reset(wdog_reset), .wdog_mode(wdog_mode),
    .int_pending(int_pending));

// *** sim/uc_host.sv ***
// Microcontroller model that services the watchdog over APB
`timescale 1ns/1ps

// ========================================
// Host model
module uc_host (
    // Clock
    input wire pclk,
    // Requests
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    // Answers
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr
);
    // Idle bus from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    int n_tout = 0; // Transfers that never saw pready
    // One transfer; gives up after 16 access cycles
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) n_tout++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines show no stale value
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule // uc_host

// *** sim/window_timeout_watchdog_bench.sv ***
// Self-checking bench for the window and timeout watchdog
`timescale 1ns/1ps
`include "wdt_defines.vh"

// ========================================
// Bench
module window_timeout_watchdog_bench;
    logic pclk = 1'b0;
    logic presetn, ce, wake_event, watchdog_disable_pin;
    logic [2:0] chip_mode;
    wire psel, penable, pwrite, pready, pslverr, wdog_reset, int_pending;
    wire [7:0] paddr;
    wire [31:0] pwdata, prdata;
    wire [1:0] wdog_mode;
    int n_fail = 0;
    int checks_done = 0;
    int n_rst = 0; // Reset pulses seen
    int cyc_n; // Cycles spent waiting
    logic [31:0] rdat;
    logic rerr;
    always #12.5 pclk = ~pclk;
    // Count every watchdog reset pulse
    always @(posedge pclk) if (wdog_reset === 1'b1) n_rst <= n_rst + 1;
    // Short tick keeps the run brief: 4 clocks per ms
    window_timeout_watchdog #(.TICK_CYCLES(4)) dut (.pclk(pclk),
        .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .chip_mode(chip_mode),
        .wake_event(wake_event), .watchdog_disable_pin(watchdog_disable_pin),
        .wdog_reset(wdog_reset), .wdog_mode(wdog_mode),
        .int_pending(int_pending));
    uc_host host (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    // ========================================
    // Helpers
    task chk(input string what, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task rd(input logic [7:0] a);
        host.xfer(1'b0, a, 32'h0, rdat, rerr);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, rdat, rerr);
    endtask
    task cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // Bounded wait for a reset pulse beyond the base count
    task wait_rst(input int base, input int lim);
        cyc_n = 0;
        while (n_rst == base && cyc_n < lim) begin
            @(posedge pclk);
            cyc_n++;
        end
    endtask
    // ========================================
    // Scenarios
    task t_regs;
        rd(`WDT_ADDR_WDOG);
        chk("period code", rdat[3:0], 4'h4);
        chk("standby mode", rdat[5:4], `WD_TIMEOUT);
        rd(8'h0C);
        chk("unmapped error", rerr, 1'b1);
        $display("done: registers");
    endtask
    task t_timeout;
        int b;
        b = n_rst;
        wr(`WDT_ADDR_WDOG, 32'h0); // Shortest period, 64 clocks
        cyc_n = 0;
        while (int_pending !== 1'b1 && cyc_n < 100) begin
            @(posedge pclk);
            cyc_n++;
        end
        chk("first overflow flag", {int_pending, n_rst == b}, 2'h3);
        wr(`WDT_ADDR_INT, 32'h0);
        rd(`WDT_ADDR_INT);
        chk("flag kept on zero", rdat[0], 1'b1);
        wait_rst(b, 100);
        chk("second overflow", n_rst - b, 1);
        rd(`WDT_ADDR_STAT);
        chk("timeout cause", rdat[6:4], `CAUSE_TO_OVF);
        rd(`WDT_ADDR_WDOG);
        chk("default code", rdat[2:0], `WDT_PSEL_DEFAULT);
        wr(`WDT_ADDR_INT, 32'h1);
        cyc(2);
        chk("flag cleared", int_pending, 1'b0);
        $display("done: timeout");
    endtask
    task t_window;
        int b;
        chip_mode <= `CHIP_NORMAL;
        cyc(3);
        chk("window mode", wdog_mode, `WD_WINDOW);
        b = n_rst;
        cyc(300); // Window opens at 256 clocks
        wr(`WDT_ADDR_WDOG, 32'h4);
        cyc(5);
        chk("open trigger", n_rst - b, 0);
        wr(`WDT_ADDR_WDOG, 32'h4);
        wait_rst(b, 10);
        chk("early trigger", n_rst - b, 1);
        rd(`WDT_ADDR_STAT);
        chk("early cause", rdat[6:4], `CAUSE_EARLY);
        b = n_rst;
        wait_rst(b, 600);
        chk("window overflow", {n_rst - b == 1, cyc_n >= 490}, 2'h3);
        rd(`WDT_ADDR_STAT);
        chk("overflow cause", rdat[6:4], `CAUSE_WIN_OVF);
        $display("done: window");
    endtask
    task t_modebit;
        int b;
        chip_mode <= `CHIP_STANDBY;
        wr(`WDT_ADDR_WDOG, 32'hC);
        cyc(3);
        chk("standby bit off", wdog_mode, `WD_OFF);
        wake_event <= 1'b1;
        @(posedge pclk);
        wake_event <= 1'b0;
        cyc(4);
        chk("re-enabled", wdog_mode, `WD_TIMEOUT);
        wr(`WDT_ADDR_WDOG, 32'h4);
        rd(`WDT_ADDR_WDOG);
        chk("bit locked", rdat[3], 1'b1);
        wr(`WDT_ADDR_INT, 32'h3);
        cyc(3);
        chk("off again", wdog_mode, `WD_OFF);
        b = n_rst;
        chip_mode <= `CHIP_NORMAL;
        cyc(3);
        chk("normal bit one", wdog_mode, `WD_TIMEOUT);
        wr(`WDT_ADDR_WDOG, 32'h4);
        wait_rst(b, 10);
        rd(`WDT_ADDR_STAT);
        chk("bit change", {n_rst - b == 1, rdat[6:4]}, {1'b1, `CAUSE_CTRL});
        $display("done: mode bit");
    endtask
    task t_pin;
        int b;
        b = n_rst;
        watchdog_disable_pin <= 1'b1;
        wait_rst(b, 10);
        cyc(3);
        chk("pin rise", {n_rst - b == 1, wdog_mode}, {1'b1, `WD_OFF});
        b = n_rst;
        watchdog_disable_pin <= 1'b0;
        wait_rst(b, 10);
        rd(`WDT_ADDR_STAT);
        chk("pin fall", {n_rst - b == 1, rdat[6:4]}, {1'b1, `CAUSE_PIN});
        $display("done: pin");
    endtask
    task t_chip;
        logic [2:0] m [3];
        m = '{`CHIP_OFF, `CHIP_SLEEP, `CHIP_OVERTEMP};
        // Clock enable low holds Window mode through a chip mode change
        ce <= 1'b0;
        chip_mode <= `CHIP_OFF;
        cyc(4);
        chk("frozen mode", wdog_mode, `WD_WINDOW);
        ce <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            chip_mode <= m[k];
            cyc(3);
            chk("chip off mode", wdog_mode, `WD_OFF);
        end
        $display("done: chip modes");
    endtask
    // ========================================
    // Verdict, reached from the sequence or the watchdog
    task print_verdict;
        n_fail = n_fail + host.n_tout; // Bus timeouts are mismatches
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Hang guard, far beyond the thousand or so clocks needed
    initial begin
        #500000;
        n_fail++;
        print_verdict;
    end
    // Main sequence
    initial begin
        presetn = 1'b0;
        ce = 1'b1;
        chip_mode = `CHIP_STANDBY;
        wake_event = 1'b0;
        watchdog_disable_pin = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_timeout;
        t_window;
        t_modebit;
        t_pin;
        t_chip;
        print_verdict;
    end
endmodule // window_timeout_watchdog_bench
